/* rtl/tccp_regs.svh */
/*
 * Register offsets, field positions and reset values of the capture/compare timer.
 * Assumes an APB slave with 32-bit data; every register takes one aligned word.
 */
`ifndef TCCP_REGS_SVH
`define TCCP_REGS_SVH

// ==========================================================================
// Offsets
`define TCCP_OFS_MODE   8'h00
`define TCCP_OFS_CTRL   8'h04
`define TCCP_OFS_IEN    8'h08
`define TCCP_OFS_STAT   8'h0C
`define TCCP_OFS_IOC0   8'h10
`define TCCP_OFS_IOC1   8'h14
`define TCCP_OFS_CNT    8'h18
`define TCCP_OFS_GRA    8'h1C
`define TCCP_OFS_GRB    8'h20
`define TCCP_OFS_GRC    8'h24
`define TCCP_OFS_GRD    8'h28

// ==========================================================================
// Fields
`define TCCP_MODE_START   0
`define TCCP_MODE_PWM_LSB 1
`define TCCP_MODE_BUF_A   4
`define TCCP_MODE_BUF_B   5
`define TCCP_CTRL_CLR     0
`define TCCP_CTRL_CKS_LSB 1
`define TCCP_CTRL_LVL_LSB 4
`define TCCP_STAT_OVF     7
`define TCCP_IOC_CAP      2

// ==========================================================================
// Reset values
`define TCCP_GR_RST     16'hFFFF
`define TCCP_CNT_RST    16'h0000
`define TCCP_REG8_RST   8'h00
`define TCCP_IOC_RSVD   8'h88

`endif

/* rtl/tccp_pkg.sv */
/*
 * Types shared by the capture/compare timer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tccp_pkg;
    typedef logic [15:0] tccp_word_t;

    typedef enum logic [1:0] {
        OSEL_NONE   = 2'h0,
        OSEL_LOW    = 2'h1,
        OSEL_HIGH   = 2'h2,
        OSEL_TOGGLE = 2'h3
    } tccp_osel_e;

    typedef enum logic [2:0] {
        CKS_DIV1 = 3'h0,
        CKS_DIV2 = 3'h1,
        CKS_DIV4 = 3'h2,
        CKS_DIV8 = 3'h3,
        CKS_EXT  = 3'h4
    } tccp_cks_e;
endpackage

`default_nettype wire

/* rtl/tccp_ev_if.sv */
/*
 * Event carrier between the count clock source, the capture edge detector and the core.
 * Assumes all three sit on one clock.
 */
`default_nettype none

interface tccp_ev_if;
    logic       tick;
    logic [3:0] cap;
    modport tick_src (output tick);
    modport cap_src  (output cap);
    modport sink     (input tick, input cap);
endinterface

`default_nettype wire

/* rtl/tccp_clk_gen.sv */
/*
 * Count clock source: prescaler or external count clock, reduced to a one-cycle tick.
 * Assumes the external count clock is synchronous to the system clock.
 */
`default_nettype none

module tccp_clk_gen
    import tccp_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire tccp_cks_e sel_i,
    input  wire logic      ext_clk_i,
    tccp_ev_if.tick_src    ev
);
    logic [2:0] div_q, div_d;
    logic       ext_q, ext_d;
    logic       tick_q, tick_d;
    logic [2:0] mask;

    // ======================================================================
    // Tick on each rising edge of the selected clock
    always_comb begin
        div_d = div_q + 3'h1;
        ext_d = ext_clk_i;
        unique case (sel_i)
            CKS_DIV2: mask = 3'h1;
            CKS_DIV4: mask = 3'h3;
            CKS_DIV8: mask = 3'h7;
            default:  mask = 3'h0;
        endcase
        if (sel_i == CKS_EXT) begin
            tick_d = ext_clk_i & ~ext_q;
        end else begin
            tick_d = (div_q & mask) == mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q  <= 3'h0;
            ext_q  <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            ext_q  <= ext_d;
            tick_q <= tick_d;
        end
    end

    assign ev.tick = tick_q;
endmodule // tccp_clk_gen

`default_nettype wire

/* rtl/tccp_cap_edge.sv */
/*
 * Capture edge detector for the four timer pins.
 * Assumes pin levels are synchronous to the system clock.
 */
`default_nettype none

module tccp_cap_edge (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] pin_i,
    input  wire logic [7:0] edge_sel_i,
    tccp_ev_if.cap_src      ev
);
    logic [3:0] prev_q, prev_d;
    logic [3:0] cap_q, cap_d;

    // ======================================================================
    // 00 rising, 01 falling, 1x both
    always_comb begin
        prev_d = pin_i;
        for (int i = 0; i < 4; i++) begin
            cap_d[i] = edge_sel_i[2*i+1] ? (pin_i[i] ^ prev_q[i])
                     : edge_sel_i[2*i]   ? (~pin_i[i] & prev_q[i])
                     :                     (pin_i[i] & ~prev_q[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // Track the pin level during reset so a high idle pin gives no false edge
            prev_q <= prev_d;
            cap_q  <= 4'h0;
        end else begin
            prev_q <= prev_d;
            cap_q  <= cap_d;
        end
    end

    assign ev.cap = cap_q;
endmodule // tccp_cap_edge

`default_nettype wire

/* rtl/tccp_top.sv */
/*
 * 16-bit timer with four compare/capture registers, buffering and PWM, on APB.
 * Assumes one 10 MHz clock, synchronous active-low reset and synchronous pins.
 */
// Our own choices: the APB register port and the placing of the registers.
//
// Contract
// - After reset the counter is stopped and counts only once start is 1.
// - Rollover from FFFF to 0000 sets the overflow flag; request if enabled.
// - Clear-on-match with A in compare clears counter, sets flag A, continues.
// - A compare match drives its pin low, high or toggles it as selected.
// - A pin already at the selected level stays unchanged on match.
// - A capture register loads the counter on the selected pin edge.
// - With C buffering capture A, old A moves to C as counter loads A.
// - PWM uses A as period and B, C, D as duty for pins B, C, D.
// - In PWM, A and the PWM pins' registers act as compare; PWM pins ignore their level selects.
// - PWM level bit 1 gives high at match A, low at own match; 0 inverts.
// - Duty equal to period leaves the PWM output unchanged.
// - PWM with D buffering B: match B changes pin B and loads D into B.
// - Match signal and pin change occur as the counter leaves the equal value.
// - Clearing on match A with A holding N gives a period of N+1 counts.
// - Match flags set with the match signal, after the next count tick.
// - A capture sets the register's match/capture flag.
// - A flag clears only after a read showing 1 and a later write of 0.
// - C and D buffer A and B when their buffer enables are set.
// - With C buffering compare A, each match A loads C into A.
// - Select 00 none, 01 low, 10 high, 11 toggle; capture 00 rise, 01 fall, 1x both.
// - All four general registers reset to all ones.
`include "tccp_regs.svh"
`default_nettype none

module tccp_top
    import tccp_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        EXT_CLK_I,
    input  wire logic [3:0]  IO_PIN_I,
    output logic      [3:0]  IO_PIN_O,
    output logic      [3:0]  IO_PIN_OE_O,
    output logic             TIMER_IRQ_REQUEST_O
);
    // ======================================================================
    // State
    logic [7:0]  mode_q, mode_d, ctrl_q, ctrl_d, ien_q, ien_d;
    logic [7:0]  ioc0_q, ioc0_d, ioc1_q, ioc1_d;
    logic [4:0]  flag_q, flag_d, arm_q, arm_d;
    tccp_word_t  cnt_q, cnt_d;
    tccp_word_t  gr_q [4];
    tccp_word_t  gr_d [4];
    logic [3:0]  pin_q, pin_d, oe_q, oe_d;
    logic        irq_q, irq_d, rdy_q, rdy_d, err_q, err_d;
    logic [31:0] rdat_q, rdat_d;

    // ======================================================================
    // Decode and events
    logic        acc, wr_en, rd_en, start, pwm_on, tick_run, clr, ovf;
    logic [3:0]  pwm4, is_cap, cm, eq, cap_ev, hit;
    logic [15:0] ioc;
    logic [4:0]  clr_req;
    tccp_ev_if   ev_bus ();

    function automatic logic wr_hit(input logic [7:0] ofs);
        return wr_en && (PADDR_I == ofs);
    endfunction

    function automatic logic [7:0] stat8(input logic [4:0] f);
        return {f[4], 3'h0, f[3:0]};
    endfunction

    tccp_clk_gen u_clk (
        .clk_i     (CLOCK_I),
        .rst_n_i   (RESET_N_I),
        .sel_i     (tccp_cks_e'(ctrl_q[`TCCP_CTRL_CKS_LSB +: 3])),
        .ext_clk_i (EXT_CLK_I),
        .ev        (ev_bus.tick_src)
    );

    tccp_cap_edge u_cap (
        .clk_i      (CLOCK_I),
        .rst_n_i    (RESET_N_I),
        .pin_i      (IO_PIN_I),
        .edge_sel_i ({ioc[13:12], ioc[9:8], ioc[5:4], ioc[1:0]}),
        .ev         (ev_bus.cap_src)
    );

    always_comb begin
        acc      = PSEL_I & PENABLE_I & rdy_q;
        wr_en    = acc & PWRITE_I;
        rd_en    = acc & ~PWRITE_I;
        ioc      = {ioc1_q, ioc0_q};
        start    = mode_q[`TCCP_MODE_START];
        pwm4     = {mode_q[`TCCP_MODE_PWM_LSB +: 3], 1'b0};
        pwm_on   = |pwm4;
        tick_run = ev_bus.tick & start;
        for (int i = 0; i < 4; i++) begin
            is_cap[i] = ioc[4*i + `TCCP_IOC_CAP] & ~pwm4[i] & ~(i == 0 && pwm_on);
            eq[i]     = cnt_q == gr_q[i];
            cm[i]     = tick_run & eq[i] & ~is_cap[i];
            cap_ev[i] = ev_bus.cap[i] & is_cap[i];
        end
        clr = cm[0] & ctrl_q[`TCCP_CTRL_CLR];
        ovf = tick_run & (cnt_q == 16'hFFFF) & ~clr & ~wr_hit(`TCCP_OFS_CNT);
        hit = cm | cap_ev;
    end

    // ======================================================================
    // Counter and general registers
    always_comb begin
        cnt_d = cnt_q;
        for (int i = 0; i < 4; i++) begin
            gr_d[i] = gr_q[i];
        end
        if (clr) begin
            cnt_d = `TCCP_CNT_RST;
        end else if (wr_hit(`TCCP_OFS_CNT)) begin
            cnt_d = PWDATA_I[15:0];
        end else if (tick_run) begin
            cnt_d = cnt_q + 16'h0001;
        end
        for (int i = 0; i < 4; i++) begin
            if (cap_ev[i]) begin
                gr_d[i] = cnt_q;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (mode_q[`TCCP_MODE_BUF_A + i]) begin
                if (cap_ev[i]) begin
                    gr_d[i+2] = gr_q[i];
                end else if (cm[i]) begin
                    gr_d[i] = gr_q[i+2];
                end
            end
        end
        if (wr_hit(`TCCP_OFS_GRA)) gr_d[0] = PWDATA_I[15:0];
        if (wr_hit(`TCCP_OFS_GRB)) gr_d[1] = PWDATA_I[15:0];
        if (wr_hit(`TCCP_OFS_GRC)) gr_d[2] = PWDATA_I[15:0];
        if (wr_hit(`TCCP_OFS_GRD)) gr_d[3] = PWDATA_I[15:0];
    end

    // ======================================================================
    // Pins
    always_comb begin
        pin_d = pin_q;
        if (wr_hit(`TCCP_OFS_CTRL)) begin
            pin_d = PWDATA_I[`TCCP_CTRL_LVL_LSB +: 4];
        end
        for (int i = 0; i < 4; i++) begin
            oe_d[i] = pwm4[i] | (~is_cap[i] & (ioc[4*i +: 2] != OSEL_NONE));
            if (pwm4[i]) begin
                if (gr_q[i] != gr_q[0]) begin
                    if (cm[0]) pin_d[i] = ctrl_q[`TCCP_CTRL_LVL_LSB + i];
                    if (cm[i]) pin_d[i] = ~ctrl_q[`TCCP_CTRL_LVL_LSB + i];
                end
            end else if (cm[i]) begin
                unique case (tccp_osel_e'(ioc[4*i +: 2]))
                    OSEL_LOW:    pin_d[i] = 1'b0;
                    OSEL_HIGH:   pin_d[i] = 1'b1;
                    OSEL_TOGGLE: pin_d[i] = ~pin_q[i];
                    OSEL_NONE:   pin_d[i] = pin_q[i];
                endcase
            end
        end
    end

    // ======================================================================
    // Registers, flags and APB
    always_comb begin
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        ien_d  = ien_q;
        ioc0_d = ioc0_q;
        ioc1_d = ioc1_q;
        if (wr_hit(`TCCP_OFS_MODE)) mode_d = {2'h0, PWDATA_I[5:0]};
        if (wr_hit(`TCCP_OFS_CTRL)) ctrl_d = PWDATA_I[7:0];
        if (wr_hit(`TCCP_OFS_IEN))  ien_d  = PWDATA_I[7:0] & stat8(5'h1F);
        if (wr_hit(`TCCP_OFS_IOC0)) ioc0_d = PWDATA_I[7:0] | `TCCP_IOC_RSVD;
        if (wr_hit(`TCCP_OFS_IOC1)) ioc1_d = PWDATA_I[7:0] | `TCCP_IOC_RSVD;
        clr_req = {5{wr_hit(`TCCP_OFS_STAT)}} & arm_q
                & ~{PWDATA_I[`TCCP_STAT_OVF], PWDATA_I[3:0]};
        flag_d = (flag_q & ~clr_req) | {ovf, hit};
        // Arm only the bits the master actually saw as 1 in the returned word
        arm_d  = (rd_en && PADDR_I == `TCCP_OFS_STAT)
               ? {rdat_q[`TCCP_STAT_OVF], rdat_q[3:0]} : (arm_q & flag_d);
        irq_d  = |(stat8(flag_d) & ien_q);
        rdy_d  = PSEL_I & PENABLE_I & ~rdy_q;
        err_d  = 1'b0;
        rdat_d = 32'h0000_0000;
        unique case (PADDR_I)
            `TCCP_OFS_MODE: rdat_d[7:0]  = mode_q;
            `TCCP_OFS_CTRL: rdat_d[7:0]  = ctrl_q;
            `TCCP_OFS_IEN:  rdat_d[7:0]  = ien_q;
            `TCCP_OFS_STAT: rdat_d[7:0]  = stat8(flag_q);
            `TCCP_OFS_IOC0: rdat_d[7:0]  = ioc0_q;
            `TCCP_OFS_IOC1: rdat_d[7:0]  = ioc1_q;
            `TCCP_OFS_CNT:  rdat_d[15:0] = cnt_q;
            `TCCP_OFS_GRA:  rdat_d[15:0] = gr_q[0];
            `TCCP_OFS_GRB:  rdat_d[15:0] = gr_q[1];
            `TCCP_OFS_GRC:  rdat_d[15:0] = gr_q[2];
            `TCCP_OFS_GRD:  rdat_d[15:0] = gr_q[3];
            default:        err_d        = rdy_d;
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            mode_q <= `TCCP_REG8_RST;
            ctrl_q <= `TCCP_REG8_RST;
            ien_q  <= `TCCP_REG8_RST;
            ioc0_q <= `TCCP_IOC_RSVD;
            ioc1_q <= `TCCP_IOC_RSVD;
            flag_q <= 5'h00;
            arm_q  <= 5'h00;
            cnt_q  <= `TCCP_CNT_RST;
            for (int i = 0; i < 4; i++) gr_q[i] <= `TCCP_GR_RST;
            pin_q  <= 4'h0;
            oe_q   <= 4'h0;
            irq_q  <= 1'b0;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            ien_q  <= ien_d;
            ioc0_q <= ioc0_d;
            ioc1_q <= ioc1_d;
            flag_q <= flag_d;
            arm_q  <= arm_d;
            cnt_q  <= cnt_d;
            for (int i = 0; i < 4; i++) gr_q[i] <= gr_d[i];
            pin_q  <= pin_d;
            oe_q   <= oe_d;
            irq_q  <= irq_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            rdat_q <= rdat_d;
        end
    end

    assign PRDATA_O            = rdat_q;
    assign PREADY_O            = rdy_q;
    assign PSLVERR_O           = err_q;
    assign IO_PIN_O            = pin_q;
    assign IO_PIN_OE_O         = oe_q;
    assign TIMER_IRQ_REQUEST_O = irq_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    a_count_stopped_hold: assert property (!start && !wr_hit(`TCCP_OFS_CNT) |=> $stable(cnt_q))
        else $error("counter moved while stopped");
    a_overflow_flag_set: assert property (ovf |=> flag_q[4] && cnt_q == 16'h0000)
        else $error("overflow not flagged");
    a_period_clear_zero: assert property (clr |=> cnt_q == 16'h0000 && flag_q[0])
        else $error("match A did not clear counter");
    a_match_flag_set: assert property (cm[1] |=> flag_q[1] && cnt_q != $past(cnt_q))
        else $error("match B flag late");
    a_cmp_low_drive: assert property (cm[2] && !pwm4[2] && ioc[9:8] == 2'h1 |=> !IO_PIN_O[2])
        else $error("low output not driven");
    a_cmp_toggle_pin: assert property (cm[3] && !pwm4[3] && ioc[13:12] == 2'h3
        |=> IO_PIN_O[3] != $past(IO_PIN_O[3]))
        else $error("toggle output missing");
    a_capture_load_cnt: assert property (cap_ev[1] && !wr_hit(`TCCP_OFS_GRB)
        |=> gr_q[1] == $past(cnt_q) && flag_q[1])
        else $error("capture B wrong");
    a_capture_buf_shift: assert property (cap_ev[0] && mode_q[`TCCP_MODE_BUF_A]
        && PADDR_I != `TCCP_OFS_GRC && !wr_hit(`TCCP_OFS_GRA) |=> gr_q[2] == $past(gr_q[0]))
        else $error("capture buffer shift wrong");
    a_pwm_period_level: assert property (cm[0] && pwm4[1] && gr_q[1] != gr_q[0]
        |=> IO_PIN_O[1] == $past(ctrl_q[`TCCP_CTRL_LVL_LSB + 1]))
        else $error("pwm period level wrong");
    a_pwm_equal_hold: assert property (pwm4[2] && gr_q[2] == gr_q[0] && !wr_hit(`TCCP_OFS_CTRL)
        |=> $stable(IO_PIN_O[2]))
        else $error("pwm pin moved at equal duty");
    a_flag_needs_read: assert property (flag_q[0] && !arm_q[0] && wr_hit(`TCCP_OFS_STAT)
        |=> flag_q[0])
        else $error("flag cleared without read");

    c_periodic_clear: cover property (clr ##1 tick_run [*3]);
    c_capture_buffer: cover property (cap_ev[0] && mode_q[`TCCP_MODE_BUF_A]);
    c_pwm_cycle: cover property (cm[0] && pwm4[1] ##[1:200] cm[1]);
    c_flag_cleared: cover property (flag_q[0] ##1 !flag_q[0]);
endmodule // tccp_top

`default_nettype wire

/* dv/tccp_pin_model.sv */
/*
 * Far-side model: capture pin levels and external count clock.
 * Assumes the bench resolves pins against the timer's output enables.
 */
`default_nettype none

module tccp_pin_model (
    input  wire logic       clk_i,
    output logic      [3:0] pin_o,
    output logic            ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        pin_o = 4'h0;
        ext_clk_o = 1'b0;
    end

    // ==========================================================
    // Each level is held three clocks before anything else moves
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_i);
        pin_o[idx] <= lvl;
        repeat (3) @(posedge clk_i);
    endtask

    // Count clock stands low outside a burst
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_clk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_clk_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule // tccp_pin_model

`default_nettype wire

/* dv/timer_capture_compare_pwm_test.sv */
/*
 * Self-checking bench for the capture/compare timer over APB.
 * Assumes the register map and one-wait-state answer of the design.
 */
`include "tccp_regs.svh"
`default_nettype none

module timer_capture_compare_pwm_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        last_err;
    logic [31:0] rv;
    wire  logic  ext_clk;
    wire  logic [3:0] mdl_pin;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic        irq;
    wire  logic [3:0] pin_lvl = (io_oe & io_o) | (~io_oe & mdl_pin);
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          hi;
    int          lo;
    logic [1:0]  sels [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    logic        inits [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic        exps [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    always #50 clk = ~clk;

    tccp_top uut (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_CLK_I(ext_clk),
        .IO_PIN_I(pin_lvl), .IO_PIN_O(io_o), .IO_PIN_OE_O(io_oe),
        .TIMER_IRQ_REQUEST_O(irq)
    );

    tccp_pin_model u_pin (.clk_i(clk), .pin_o(mdl_pin), .ext_clk_o(ext_clk));

    // ==========================================================
    // Helpers
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Edge-to-edge high and low lengths of one pin, in clocks
    task automatic measure(input int i);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (io_o[i] !== 1'b0 && n < 99) begin @(posedge clk); n++; end
        while (io_o[i] !== 1'b1 && n < 99) begin @(posedge clk); n++; end
        while (io_o[i] === 1'b1 && n < 99) begin @(posedge clk); n++; hi++; end
        while (io_o[i] === 1'b0 && n < 99) begin @(posedge clk); n++; lo++; end
    endtask

    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 4; k++) rd(8'h1C + 8'(4 * k), 32'hFFFF);
        rd(`TCCP_OFS_IOC0, 32'h88);
        rd(8'h40, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        repeat (20) @(posedge clk);
        rd(`TCCP_OFS_CNT, 32'h0);
        $display("test reset done");

        wr(`TCCP_OFS_CNT, 32'hFFFD);
        wr(`TCCP_OFS_IEN, 32'h80);
        wr(`TCCP_OFS_MODE, 32'h1);
        repeat (10) @(posedge clk);
        wr(`TCCP_OFS_MODE, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(`TCCP_OFS_STAT, 32'h0);
        rd(`TCCP_OFS_STAT, 32'h8F);
        wr(`TCCP_OFS_STAT, 32'h0);
        rd(`TCCP_OFS_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test overflow done");

        wr(`TCCP_OFS_GRA, 32'h9);
        wr(`TCCP_OFS_CTRL, 32'h1);
        wr(`TCCP_OFS_IOC0, 32'h3);
        wr(`TCCP_OFS_CNT, 32'h0);
        wr(`TCCP_OFS_MODE, 32'h1);
        measure(0);
        chk(hi, 10);
        chk(lo, 10);
        wr(`TCCP_OFS_MODE, 32'h0);
        rd(`TCCP_OFS_STAT, 32'h1);
        $display("test periodic done");

        do_reset();
        for (int k = 0; k < 5; k++) begin
            wr(`TCCP_OFS_IOC0, 32'(sels[k]) << 4);
            wr(`TCCP_OFS_CTRL, 32'(inits[k]) << 5);
            wr(`TCCP_OFS_GRB, 32'h100);
            wr(`TCCP_OFS_CNT, 32'hFE);
            wr(`TCCP_OFS_MODE, 32'h1);
            repeat (10) @(posedge clk);
            wr(`TCCP_OFS_MODE, 32'h0);
            chk({31'h0, io_o[1]}, {31'h0, exps[k]});
        end
        chk({31'h0, io_oe[1]}, 32'h0);
        $display("test compare done");

        rd(`TCCP_OFS_STAT, 32'h2);
        wr(`TCCP_OFS_STAT, 32'h0);
        for (int s = 0; s < 3; s++) begin
            wr(`TCCP_OFS_GRA, 32'hFFFF);
            wr(`TCCP_OFS_IOC0, 32'h4 + s);
            wr(`TCCP_OFS_CNT, 32'h1000 + s);
            u_pin.set_pin(0, 1'b1);
            rd(`TCCP_OFS_GRA, (s != 1) ? 32'h1000 + s : 32'hFFFF);
            wr(`TCCP_OFS_CNT, 32'h2000 + s);
            u_pin.set_pin(0, 1'b0);
            rd(`TCCP_OFS_GRA, (s != 0) ? 32'h2000 + s : 32'h1000);
            rd(`TCCP_OFS_STAT, 32'h1);
            wr(`TCCP_OFS_STAT, 32'h0);
        end
        wr(`TCCP_OFS_MODE, 32'h10);
        wr(`TCCP_OFS_IOC0, 32'h6);
        wr(`TCCP_OFS_CNT, 32'hAAA);
        u_pin.set_pin(0, 1'b1);
        wr(`TCCP_OFS_CNT, 32'hBBB);
        u_pin.set_pin(0, 1'b0);
        rd(`TCCP_OFS_GRA, 32'hBBB);
        rd(`TCCP_OFS_GRC, 32'hAAA);
        $display("test capture done");

        do_reset();
        wr(`TCCP_OFS_CTRL, 32'h8);
        wr(`TCCP_OFS_MODE, 32'h1);
        u_pin.ext_pulses(5);
        repeat (4) @(posedge clk);
        wr(`TCCP_OFS_MODE, 32'h0);
        rd(`TCCP_OFS_CNT, 32'h5);
        $display("test ext clock done");

        do_reset();
        wr(`TCCP_OFS_GRA, 32'h9);
        wr(`TCCP_OFS_GRB, 32'h3);
        wr(`TCCP_OFS_GRC, 32'h9);
        wr(`TCCP_OFS_CTRL, 32'h21);
        wr(`TCCP_OFS_MODE, 32'h7);
        measure(1);
        chk(hi, 4);
        chk(lo, 6);
        chk({30'h0, io_oe[2], io_o[2]}, 32'h2);
        wr(`TCCP_OFS_GRD, 32'h5);
        wr(`TCCP_OFS_MODE, 32'h27);
        repeat (12) @(posedge clk);
        measure(1);
        chk(hi, 6);
        chk(lo, 4);
        rd(`TCCP_OFS_GRB, 32'h5);
        wr(`TCCP_OFS_GRC, 32'h7);
        wr(`TCCP_OFS_MODE, 32'h37);
        repeat (12) @(posedge clk);
        rd(`TCCP_OFS_GRA, 32'h7);
        $display("test pwm done");
        tally_and_finish();
    end
endmodule // timer_capture_compare_pwm_test

`default_nettype wire
